/* pcm_serial_port.sv */
// serial pcm input/output port with ahb-lite register access
// assumes all pcm-side input pins are asynchronous and pass the two-flop synchroniser
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module pcm_serial_port
  import pcm_port_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        SERIAL_IN_PIN_I,
  input  wire logic        RX_BIT_CLOCK_I,
  output logic             RX_BIT_CLOCK_O,
  output logic             RX_BIT_CLOCK_OE_O,
  input  wire logic        RX_LOAD_STROBE_I,
  output logic             RX_LOAD_STROBE_O,
  output logic             RX_LOAD_STROBE_OE_O,
  input  wire logic        TX_BIT_CLOCK_I,
  output logic             TX_BIT_CLOCK_O,
  output logic             TX_BIT_CLOCK_OE_O,
  input  wire logic        TX_LOAD_STROBE_I,
  output logic             TX_LOAD_STROBE_O,
  output logic             TX_LOAD_STROBE_OE_O,
  input  wire logic        FRAME_SYNC_I,
  output logic             FRAME_SYNC_O,
  output logic             FRAME_SYNC_OE_O,
  output logic             SERIAL_OUT_O,
  output logic             SERIAL_OUT_OE_O,
  input  wire logic        SERIAL_OUT_ENABLE_N_I,
  output logic             RX_BUFFER_FULL_O,
  output logic             RX_BUFFER_FULL_OE_O,
  output logic             TX_BUFFER_EMPTY_O,
  output logic             TX_BUFFER_EMPTY_OE_O,
  output logic             TX_SHIFT_EMPTY_O,
  output logic             TX_SHIFT_EMPTY_OE_O,
  input  wire logic        RESET_N_INPUT_I,
  input  wire logic        TRISTATE_ALL_N_I,
  output logic             IRQ_O
);
  logic              rxck_rise;
  logic              rxld_rise;
  logic              txck_fall;
  logic              txld_rise;
  logic              sync_s;
  logic              din_s;
  logic              oen_n_s;
  logic              rstn_s;
  logic              tri_n_s;
  logic [31:0]       ctrl_q;
  logic              int_mode;
  logic [LEN_W-1:0]  len_bits;
  logic [DIV_W-1:0]  div_cnt_q;
  logic              gen_clk_q;
  logic              gen_ld_q;
  logic [LEN_W-1:0]  bit_cnt_q;
  logic              gen_tick;
  logic              gen_rise;
  logic              gen_fall;
  logic              gen_ld_rise;
  logic              rx_rise;
  logic              rx_ld_rise;
  logic              tx_fall;
  logic              tx_ld_rise;
  logic [WORD_W-1:0] rx_sh_data;
  logic [WORD_W-1:0] tx_sh_data;
  logic              tx_msb;
  logic [WORD_W-1:0] rx_buf_q;
  logic [WORD_W-1:0] tx_buf_q;
  logic              rx_full_q;
  logic              tx_empty_q;
  logic [LEN_W-1:0]  tx_left_q;
  logic              tx_she;
  logic              ap;
  logic              dp_wr_q;
  logic [7:0]        dp_addr_q;
  logic              rd_rx;
  logic              wr_tx;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_en_q;
  logic [IRQ_W-1:0]  irq_ev;
  logic              halt;
  pcm_edge_sync #(.INIT(1'b0)) u_rxck (.clk_i(CLK_SYS_I), .rst_i(RESET_I),
    .pin_i(RX_BIT_CLOCK_I), .level_o(), .rise_o(rxck_rise), .fall_o());
  pcm_edge_sync #(.INIT(1'b0)) u_rxld (.clk_i(CLK_SYS_I), .rst_i(RESET_I),
    .pin_i(RX_LOAD_STROBE_I), .level_o(), .rise_o(rxld_rise), .fall_o());
  pcm_edge_sync #(.INIT(1'b0)) u_txck (.clk_i(CLK_SYS_I), .rst_i(RESET_I),
    .pin_i(TX_BIT_CLOCK_I), .level_o(), .rise_o(), .fall_o(txck_fall));
  pcm_edge_sync #(.INIT(1'b0)) u_txld (.clk_i(CLK_SYS_I), .rst_i(RESET_I),
    .pin_i(TX_LOAD_STROBE_I), .level_o(), .rise_o(txld_rise), .fall_o());
  pcm_edge_sync #(.INIT(1'b0)) u_sync (.clk_i(CLK_SYS_I), .rst_i(RESET_I),
    .pin_i(FRAME_SYNC_I), .level_o(sync_s), .rise_o(), .fall_o());
  pcm_edge_sync #(.INIT(1'b0)) u_din (.clk_i(CLK_SYS_I), .rst_i(RESET_I),
    .pin_i(SERIAL_IN_PIN_I), .level_o(din_s), .rise_o(), .fall_o());
  pcm_edge_sync #(.INIT(1'b1)) u_oen (.clk_i(CLK_SYS_I), .rst_i(RESET_I),
    .pin_i(SERIAL_OUT_ENABLE_N_I), .level_o(oen_n_s), .rise_o(), .fall_o());
  pcm_edge_sync #(.INIT(1'b1)) u_rstn (.clk_i(CLK_SYS_I), .rst_i(RESET_I),
    .pin_i(RESET_N_INPUT_I), .level_o(rstn_s), .rise_o(), .fall_o());
  pcm_edge_sync #(.INIT(1'b1)) u_tri (.clk_i(CLK_SYS_I), .rst_i(RESET_I),
    .pin_i(TRISTATE_ALL_N_I), .level_o(tri_n_s), .rise_o(), .fall_o());
  assign halt     = ~rstn_s;
  assign int_mode = ctrl_q[CTRL_INT_BIT];
  // a zero length field means a full 32-bit word
  assign len_bits = (ctrl_q[CTRL_LEN_LSB +: CTRL_LEN_W] == 5'h00) ? 6'h20
                  : {1'b0, ctrl_q[CTRL_LEN_LSB +: CTRL_LEN_W]};
  // internal bit clock, load strobe and frame sync generator
  assign gen_tick    = int_mode && (div_cnt_q == ctrl_q[CTRL_DIV_LSB +: DIV_W]);
  assign gen_rise    = gen_tick && !gen_clk_q;
  assign gen_fall    = gen_tick && gen_clk_q;
  assign gen_ld_rise = gen_fall && (bit_cnt_q == 6'(len_bits - 6'd1));
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I || halt || !int_mode)
    begin
      div_cnt_q <= 8'h00;
      gen_clk_q <= 1'b0;
      gen_ld_q  <= 1'b0;
      bit_cnt_q <= 6'h00;
    end
    else
    begin
      div_cnt_q <= gen_tick ? 8'h00 : 8'(div_cnt_q + 8'h01);
      if (gen_tick)
        gen_clk_q <= ~gen_clk_q;
      if (gen_fall)
      begin
        bit_cnt_q <= gen_ld_rise ? 6'h00 : 6'(bit_cnt_q + 6'h01);
        gen_ld_q  <= gen_ld_rise;
      end
    end
  end
  // edge sources follow the direction chosen in control
  assign rx_rise    = !halt && (int_mode ? gen_rise : rxck_rise);
  assign rx_ld_rise = !halt && (int_mode ? gen_ld_rise : rxld_rise);
  assign tx_fall    = !halt && (int_mode ? gen_fall : txck_fall);
  assign tx_ld_rise = !halt && (int_mode ? gen_ld_rise : txld_rise);
  // receive shifts on rising bit clock edges
  pcm_shift #(.W(WORD_W)) u_rx_sh (
    .clk_i       (CLK_SYS_I),
    .rst_i       (RESET_I),
    .load_i      (1'b0),
    .load_data_i ('0),
    .shift_i     (rx_rise),
    .bit_i       (din_s),
    .len_i       (len_bits),
    .data_o      (rx_sh_data),
    .msb_o       ()
  );
  // transmit changes data on falling edges, loading takes priority
  pcm_shift #(.W(WORD_W)) u_tx_sh (
    .clk_i       (CLK_SYS_I),
    .rst_i       (RESET_I),
    .load_i      (tx_ld_rise),
    .load_data_i (tx_buf_q),
    .shift_i     (tx_fall && !tx_ld_rise),
    .bit_i       (1'b0),
    .len_i       (len_bits),
    .data_o      (tx_sh_data),
    .msb_o       (tx_msb)
  );
  // ahb-lite slave, zero wait states
  assign ap    = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign rd_rx = ap && !HWRITE_I && (HADDR_I[7:0] == RXDATA_OFS);
  assign wr_tx = dp_wr_q && (dp_addr_q == TXDATA_OFS);
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      dp_wr_q     <= 1'b0;
      dp_addr_q   <= 8'h00;
      HRDATA_O    <= 32'h0000_0000;
      HREADYOUT_O <= 1'b0;
      HRESP_O     <= 1'b0;
    end
    else
    begin
      HREADYOUT_O <= 1'b1;
      dp_wr_q     <= ap && HWRITE_I;
      dp_addr_q   <= HADDR_I[7:0];
      if (ap && !HWRITE_I)
      begin
        unique case (HADDR_I[7:0])
          CTRL_OFS:     HRDATA_O <= ctrl_q;
          STATUS_OFS:   HRDATA_O <= {28'h0000000, sync_s, tx_she, tx_empty_q, rx_full_q};
          RXDATA_OFS:   HRDATA_O <= rx_buf_q;
          IRQ_STAT_OFS: HRDATA_O <= {28'h0000000, irq_stat_q};
          IRQ_EN_OFS:   HRDATA_O <= {28'h0000000, irq_en_q};
          default:      HRDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end
  // control is held cleared while the reset pin is low
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I || halt)
      ctrl_q <= CTRL_RESET;
    else if (dp_wr_q && dp_addr_q == CTRL_OFS)
      ctrl_q <= HWDATA_I;
  end
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      tx_buf_q <= 32'h0000_0000;
    else if (wr_tx)
      tx_buf_q <= HWDATA_I;
  end
  // receive buffer and its full flag; the load sets and wins over a read
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I || halt)
    begin
      rx_buf_q  <= 32'h0000_0000;
      rx_full_q <= RX_FULL_RESET;
    end
    else if (rx_ld_rise)
    begin
      rx_buf_q  <= rx_sh_data & (32'hffff_ffff >> (6'h20 - len_bits));
      rx_full_q <= 1'b1;
    end
    else if (rd_rx)
      rx_full_q <= 1'b0;
  end
  // transmit buffer empty flag: the copy sets and wins over a write
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I || halt)
      tx_empty_q <= TX_EMPTY_RESET;
    else if (tx_ld_rise)
      tx_empty_q <= 1'b1;
    else if (wr_tx)
      tx_empty_q <= 1'b0;
  end
  // bits still to send after a load; shift-empty reads one when this count is zero
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I || halt)
      tx_left_q <= 6'h00;
    else if (tx_ld_rise)
      tx_left_q <= len_bits;
    else if (tx_fall && tx_left_q != 6'h00)
      tx_left_q <= 6'(tx_left_q - 6'h01);
  end
  assign tx_she = (tx_left_q == 6'h00);
  // sticky events; a new event wins over a clear in the same cycle
  assign irq_ev[IRQ_RX_FULL]    = rx_ld_rise;
  assign irq_ev[IRQ_TX_EMPTY]   = tx_ld_rise;
  assign irq_ev[IRQ_TX_DONE]    = tx_fall && (tx_left_q == 6'h01) && !tx_ld_rise;
  assign irq_ev[IRQ_RX_OVERRUN] = rx_ld_rise && rx_full_q && !rd_rx;
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      irq_stat_q <= 4'h0;
    else if (dp_wr_q && dp_addr_q == IRQ_CLR_OFS)
      irq_stat_q <= (irq_stat_q & ~HWDATA_I[IRQ_W-1:0]) | irq_ev;
    else
      irq_stat_q <= irq_stat_q | irq_ev;
  end
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      irq_en_q <= 4'h0;
    else if (dp_wr_q && dp_addr_q == IRQ_EN_OFS)
      irq_en_q <= HWDATA_I[IRQ_W-1:0];
  end
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(irq_stat_q & irq_en_q);
  end
  // pin drivers; the three-state input overrides every enable
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      RX_BIT_CLOCK_O       <= 1'b0;
      RX_BIT_CLOCK_OE_O    <= 1'b0;
      RX_LOAD_STROBE_O     <= 1'b0;
      RX_LOAD_STROBE_OE_O  <= 1'b0;
      TX_BIT_CLOCK_O       <= 1'b0;
      TX_BIT_CLOCK_OE_O    <= 1'b0;
      TX_LOAD_STROBE_O     <= 1'b0;
      TX_LOAD_STROBE_OE_O  <= 1'b0;
      FRAME_SYNC_O         <= 1'b0;
      FRAME_SYNC_OE_O      <= 1'b0;
      SERIAL_OUT_O         <= 1'b0;
      SERIAL_OUT_OE_O      <= 1'b0;
      RX_BUFFER_FULL_O     <= 1'b0;
      RX_BUFFER_FULL_OE_O  <= 1'b0;
      TX_BUFFER_EMPTY_O    <= 1'b0;
      TX_BUFFER_EMPTY_OE_O <= 1'b0;
      TX_SHIFT_EMPTY_O     <= 1'b0;
      TX_SHIFT_EMPTY_OE_O  <= 1'b0;
    end
    else
    begin
      RX_BIT_CLOCK_O       <= gen_clk_q;
      RX_BIT_CLOCK_OE_O    <= tri_n_s && int_mode;
      RX_LOAD_STROBE_O     <= gen_ld_q;
      RX_LOAD_STROBE_OE_O  <= tri_n_s && int_mode;
      TX_BIT_CLOCK_O       <= gen_clk_q;
      TX_BIT_CLOCK_OE_O    <= tri_n_s && int_mode;
      TX_LOAD_STROBE_O     <= gen_ld_q;
      TX_LOAD_STROBE_OE_O  <= tri_n_s && int_mode;
      FRAME_SYNC_O         <= int_mode ? gen_ld_q : ctrl_q[CTRL_GP_VAL_BIT];
      FRAME_SYNC_OE_O      <= tri_n_s && (int_mode || ctrl_q[CTRL_GP_SEL_BIT]);
      SERIAL_OUT_O         <= tx_msb;
      SERIAL_OUT_OE_O      <= tri_n_s && !oen_n_s;
      RX_BUFFER_FULL_O     <= rx_full_q;
      RX_BUFFER_FULL_OE_O  <= tri_n_s;
      TX_BUFFER_EMPTY_O    <= tx_empty_q;
      TX_BUFFER_EMPTY_OE_O <= tri_n_s;
      TX_SHIFT_EMPTY_O     <= tx_she;
      TX_SHIFT_EMPTY_OE_O  <= tri_n_s;
    end
  end
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);
  AST_RX_CLEAR: assert property (rd_rx && !rx_ld_rise && !halt |=> ##1 !RX_BUFFER_FULL_O)
    else $error("receive full pin not cleared after read");
  AST_DIR_EXT: assert property (!int_mode |=> !RX_BIT_CLOCK_OE_O && !TX_LOAD_STROBE_OE_O)
    else $error("clock pin driven in external mode");
  AST_RX_LOAD: assert property (rx_ld_rise |=> rx_full_q && rx_buf_q[0] == $past(rx_sh_data[0]))
    else $error("receive load did not fill the buffer");
  AST_OUT_ENABLE: assert property (oen_n_s |=> !SERIAL_OUT_OE_O)
    else $error("serial output driven while disabled");
  AST_TX_CLEAR: assert property (wr_tx && !tx_ld_rise && !halt |=> ##1 !TX_BUFFER_EMPTY_O)
    else $error("transmit empty pin not cleared after write");
  AST_TX_LOAD: assert property (tx_ld_rise |=> tx_sh_data == $past(tx_buf_q) && tx_empty_q)
    else $error("transmit load did not copy the buffer");
  AST_SHIFT_EMPTY: assert property (tx_ld_rise |=> tx_left_q == $past(len_bits) && !tx_she)
    else $error("shift empty not held for the word length");
  AST_SYNC_INT: assert property (int_mode && tri_n_s |=> FRAME_SYNC_OE_O && FRAME_SYNC_O == $past(gen_ld_q))
    else $error("frame sync not driven in internal mode");
  AST_GP_PIN: assert property (!int_mode && ctrl_q[CTRL_GP_SEL_BIT] && tri_n_s |=> FRAME_SYNC_OE_O)
    else $error("status pin not driven");
  AST_HALT: assert property (halt |=> ctrl_q == CTRL_RESET)
    else $error("control not cleared while halted");
  AST_TRISTATE: assert property (!tri_n_s |=> !SERIAL_OUT_OE_O && !RX_BUFFER_FULL_OE_O && !FRAME_SYNC_OE_O)
    else $error("pin driven while three-stated");
  COV_RX_LOAD: cover property (rx_ld_rise ##[1:20] rd_rx);
  COV_TX_LOAD: cover property (wr_tx ##[1:1000] tx_ld_rise);
  COV_SHE: cover property (!tx_she ##1 tx_she);
  COV_IRQ: cover property (!IRQ_O ##1 IRQ_O);
endmodule

/* pcm_port_pkg.sv */
// constants shared by the serial pcm port and its helper modules
// assumes a 32-bit ahb-lite register bus and a single system clock
package pcm_port_pkg;
  localparam int WORD_W = 32;
  localparam int LEN_W  = 6;
  localparam int DIV_W  = 8;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] RXDATA_OFS   = 8'h08;
  localparam logic [7:0] TXDATA_OFS   = 8'h0c;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h18;

  // control fields
  localparam int CTRL_INT_BIT    = 0;
  localparam int CTRL_GP_SEL_BIT = 1;
  localparam int CTRL_GP_VAL_BIT = 2;
  localparam int CTRL_LEN_LSB    = 8;
  localparam int CTRL_LEN_W      = 5;
  localparam int CTRL_DIV_LSB    = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status fields
  localparam int ST_RX_FULL_BIT  = 0;
  localparam int ST_TX_EMPTY_BIT = 1;
  localparam int ST_TX_SHE_BIT   = 2;
  localparam int ST_SYNC_BIT     = 3;
  localparam logic RX_FULL_RESET  = 1'b0;
  localparam logic TX_EMPTY_RESET = 1'b1;

  // interrupt fields
  localparam int IRQ_W           = 4;
  localparam int IRQ_RX_FULL     = 0;
  localparam int IRQ_TX_EMPTY    = 1;
  localparam int IRQ_TX_DONE     = 2;
  localparam int IRQ_RX_OVERRUN  = 3;
endpackage

/* pcm_edge_sync.sv */
// two-flop synchroniser for one pin with edge detection on the clean side
// assumes the pin is asynchronous to the system clock
`timescale 1ns/1ps
module pcm_edge_sync
#(
  parameter logic INIT = 1'b0
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // meta_q feeds sync_q only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
      prev_q <= INIT;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;
  assign fall_o  = ~sync_q & prev_q;
endmodule

/* pcm_shift.sv */
// shift register used for both directions, msb first
// assumes load and shift pulses last one system clock
`timescale 1ns/1ps
module pcm_shift
  import pcm_port_pkg::*;
#(
  parameter int W = WORD_W
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic [W-1:0]     load_data_i,
  input  wire logic             shift_i,
  input  wire logic             bit_i,
  input  wire logic [LEN_W-1:0] len_i,
  output logic      [W-1:0]     data_o,
  output logic                  msb_o
);
  logic [W-1:0] data_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      data_q <= '0;
    else if (load_i)
      data_q <= load_data_i;
    else if (shift_i)
      data_q <= {data_q[W-2:0], bit_i};
  end

  assign data_o = data_q;
  // the word sits in the low len bits, so its first bit is len-1
  assign msb_o  = data_q[5'(len_i - 6'd1)];

  // one shift pulse moves the word by exactly one place and takes in one new bit
  AST_SHIFT_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    shift_i && !load_i |=> data_q == {$past(data_q[W-2:0]), $past(bit_i)})
    else $error("shift register did not move by one bit");
  AST_LOAD_WORD: assert property (@(posedge clk_i) disable iff (rst_i)
    load_i |=> data_q == $past(load_data_i))
    else $error("shift register did not take the loaded word");
endmodule

/* pcm_codec_model.sv */
// behavioural serial pcm codec on the far side of the port, external mode only
// assumes the bench resolves each two-way pin from the port's output enable alone
`timescale 1ns/1ps
module pcm_codec_model
(
  input  wire logic dout_i,
  output logic      din_o,
  output logic      rx_clk_o,
  output logic      rx_ld_o,
  output logic      tx_clk_o,
  output logic      tx_ld_o,
  output logic      fsync_o
);
  // half of the 48 ns bit clock; clocks stand still between frames
  localparam time HALF = 24ns;

  initial
  begin
    {din_o, rx_clk_o, rx_ld_o, tx_clk_o, tx_ld_o, fsync_o} = '0;
  end

  task automatic send_word(input logic [31:0] w, input int n);
    fsync_o = 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      din_o = w[i];
      #HALF rx_clk_o = 1'b1;
      #HALF rx_clk_o = 1'b0;
    end
    // a released data line must not keep showing the last bit
    din_o = ~w[0];
    rx_ld_o = 1'b1;
    #HALF rx_ld_o = 1'b0;
    fsync_o = 1'b0;
    #HALF;
  endtask

  task automatic recv_word(output logic [31:0] w, input int n);
    w = '0;
    tx_ld_o = 1'b1;
    #HALF tx_ld_o = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      #HALF w[i] = dout_i;
      tx_clk_o = 1'b1;
      #HALF tx_clk_o = 1'b0;
    end
    #HALF;
  endtask
endmodule

/* test_pcm_serial_port.sv */
// self-checking bench for the serial pcm port: ahb-lite master tasks plus codec model
// assumes the codec model file is compiled first
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module test_pcm_serial_port
  import pcm_port_pkg::*;
;
  logic        clk, rst, hsel, hwrite, oen_n, rstn_in, tsn, hready, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q, word;
  logic        rck_o, rck_oe, rld_o, rld_oe, tck_o, tck_oe, tld_o, tld_oe, fs_o, fs_oe;
  logic        so_o, so_oe, rxf, rxf_oe, txe, txe_oe, tse, tse_oe;
  logic        m_din, m_rck, m_rld, m_tck, m_tld, m_fs;
  int          num_errors = 0;
  int          num_checks = 0;
  int          k;
  wire         rck = rck_oe ? rck_o : m_rck;
  wire         rld = rld_oe ? rld_o : m_rld;
  wire         tck = tck_oe ? tck_o : m_tck;
  wire         tld = tld_oe ? tld_o : m_tld;
  wire         fs  = fs_oe ? fs_o : m_fs;
  wire         dout = so_oe ? so_o : 1'bz;

  pcm_serial_port i_pcm_serial_port (.CLK_SYS_I(clk), .RESET_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .SERIAL_IN_PIN_I(m_din), .RX_BIT_CLOCK_I(rck),
    .RX_BIT_CLOCK_O(rck_o), .RX_BIT_CLOCK_OE_O(rck_oe), .RX_LOAD_STROBE_I(rld),
    .RX_LOAD_STROBE_O(rld_o), .RX_LOAD_STROBE_OE_O(rld_oe), .TX_BIT_CLOCK_I(tck),
    .TX_BIT_CLOCK_O(tck_o), .TX_BIT_CLOCK_OE_O(tck_oe), .TX_LOAD_STROBE_I(tld),
    .TX_LOAD_STROBE_O(tld_o), .TX_LOAD_STROBE_OE_O(tld_oe), .FRAME_SYNC_I(fs),
    .FRAME_SYNC_O(fs_o), .FRAME_SYNC_OE_O(fs_oe), .SERIAL_OUT_O(so_o),
    .SERIAL_OUT_OE_O(so_oe), .SERIAL_OUT_ENABLE_N_I(oen_n), .RX_BUFFER_FULL_O(rxf),
    .RX_BUFFER_FULL_OE_O(rxf_oe), .TX_BUFFER_EMPTY_O(txe), .TX_BUFFER_EMPTY_OE_O(txe_oe),
    .TX_SHIFT_EMPTY_O(tse), .TX_SHIFT_EMPTY_OE_O(tse_oe), .RESET_N_INPUT_I(rstn_in),
    .TRISTATE_ALL_N_I(tsn), .IRQ_O(irq));

  pcm_codec_model i_codec (.dout_i(dout), .din_o(m_din), .rx_clk_o(m_rck),
    .rx_ld_o(m_rld), .tx_clk_o(m_tck), .tx_ld_o(m_tld), .fsync_o(m_fs));

  always #2.5 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // entered right after a rising edge; leaves at the edge that ends the data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    `CHK(q, exp)
  endtask

  task automatic results;
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #100000;
    num_errors++;
    results();
  end

  initial
  begin
    {clk, hwrite, oen_n, htrans, haddr, hwdata} = '0;
    {rst, hsel, rstn_in, tsn} = 4'hf;
    hsize = 3'b010;
    cyc(8);
    rst <= 1'b0;
    cyc(3);
    rd(CTRL_OFS, CTRL_RESET);
    `CHK(rxf, RX_FULL_RESET)
    `CHK(txe, TX_EMPTY_RESET)
    `CHK({rck_oe, rld_oe, tck_oe, tld_oe, fs_oe}, 5'h00)
    rd(8'h1c, 32'h0000_0000);
    // 8-bit words, external mode, all interrupts enabled
    wr(CTRL_OFS, 32'h0000_0800);
    wr(IRQ_EN_OFS, 32'h0000_000f);
    i_codec.send_word(32'h0000_00a5, 8);
    cyc(5);
    `CHK(rxf, 1'b1)
    `CHK(irq, 1'b1)
    rd(RXDATA_OFS, 32'h0000_00a5);
    cyc(4);
    `CHK(rxf, 1'b0)
    // two words with no read between: second overwrites and flags overrun
    i_codec.send_word(32'h0000_0081, 8);
    i_codec.send_word(32'h0000_005a, 8);
    cyc(5);
    // full, transmit buffer empty, shift register empty, frame sync low
    rd(STATUS_OFS, 32'h0000_0007);
    `CHK(hresp, 1'b0)
    rd(RXDATA_OFS, 32'h0000_005a);
    rd(IRQ_STAT_OFS, 32'h0000_0009);
    wr(IRQ_CLR_OFS, 32'h0000_000f);
    cyc(3);
    `CHK(irq, 1'b0)
    wr(TXDATA_OFS, 32'h0000_003c);
    cyc(3);
    `CHK(txe, 1'b0)
    fork
      i_codec.recv_word(word, 8);
      begin
        cyc(20);
        `CHK(tse, 1'b0)
        `CHK(txe, 1'b1)
      end
    join
    `CHK(word, 32'h0000_003c)
    cyc(5);
    `CHK(tse, 1'b1)
    oen_n <= 1'b1;
    cyc(4);
    `CHK(so_oe, 1'b0)
    oen_n <= 1'b0;
    cyc(4);
    `CHK(so_oe, 1'b1)
    wr(CTRL_OFS, 32'h0000_0006);
    cyc(4);
    `CHK({fs_oe, fs_o}, 2'b11)
    wr(CTRL_OFS, 32'h0001_0801);
    cyc(4);
    `CHK({rck_oe, rld_oe, tck_oe, tld_oe, fs_oe}, 5'h1f)
    for (k = 0; k < 500 && fs_o !== 1'b1; k++) @(posedge clk);
    `CHK(fs_o, 1'b1)
    `CHK({rld_o, tld_o}, 2'b11)
    tsn <= 1'b0;
    cyc(4);
    `CHK({rck_oe, rld_oe, tck_oe, tld_oe, fs_oe, so_oe, rxf_oe, txe_oe, tse_oe}, 9'h0)
    tsn <= 1'b1;
    rstn_in <= 1'b0;
    cyc(6);
    rstn_in <= 1'b1;
    cyc(4);
    rd(CTRL_OFS, CTRL_RESET);
    `CHK(rck_oe, 1'b0)
    results();
  end
endmodule
